// ---- verilog/tdm_tx_slot_mask.sv ----
// Slot-masked TDM serial transmitter with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module tdm_tx_slot_mask
	import tdm_tx_pkg::*;
#(
	parameter int max_slots = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic tx_bit_clock,
	input wire logic tx_frame_sync,
	output logic serial_tx_data_pin_o,
	output logic serial_tx_data_pin_oe,
	output logic tx_irq
);
	// The slot counter and mask select are slots_w bits wide, so no more slots fit
	if (max_slots < 1 || max_slots > (1 << slots_w)) begin : g_bad_slots
		$error("max_slots out of range");
	end

	// Pin inputs through two flops each
	logic [1:0] bclk_sync_q, fs_sync_q;
	logic bclk_prev_q, fs_prev_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bclk_sync_q <= 2'h0;
			fs_sync_q <= 2'h0;
			bclk_prev_q <= 1'b0;
			fs_prev_q <= 1'b0;
		end else begin
			bclk_sync_q <= {bclk_sync_q[0], tx_bit_clock};
			fs_sync_q <= {fs_sync_q[0], tx_frame_sync};
			bclk_prev_q <= bclk_sync_q[1];
			fs_prev_q <= fs_sync_q[1];
		end
	end
	wire bclk_rise = bclk_sync_q[1] & ~bclk_prev_q;
	wire fs_rise = fs_sync_q[1] & ~fs_prev_q;

	// Bus address phase capture
	logic wr_pend_q, rd_pend_q;
	logic [7:0] addr_q;
	wire take = hsel & hready & (htrans == htrans_nonseq);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			wr_pend_q <= take & hwrite;
			rd_pend_q <= take & ~hwrite;
			if (take)
				addr_q <= haddr[7:0];
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire wr_ctrl = wr_pend_q & (addr_q == ctrl_off);
	wire wr_mask = wr_pend_q & (addr_q == mask_off);
	wire wr_hold = wr_pend_q & (addr_q == hold_off);
	wire wr_skip = wr_pend_q & (addr_q == skip_off);
	wire wr_status = wr_pend_q & (addr_q == status_off);

	// Software registers
	logic [31:0] ctrl_q, mask_q;
	logic [15:0] hold_q;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl_q <= ctrl_rst;
			mask_q <= mask_rst;
			hold_q <= 16'h0000;
		end else begin
			if (wr_ctrl)
				ctrl_q <= hwdata;
			if (wr_mask)
				mask_q <= hwdata;
			if (wr_hold)
				hold_q <= hwdata[15:0];
		end
	end
	wire enable = ctrl_q[ctrl_en_bit];
	wire irq_en = ctrl_q[ctrl_ie_bit];
	wire [1:0] wl_sel = ctrl_q[ctrl_wl_lo +: 2];
	wire [slots_w-1:0] slots_m1 = ctrl_q[ctrl_slots_lo +: slots_w];

	function automatic logic [4:0] word_bits(input logic [1:0] sel);
		unique case (sel)
			wl_8: word_bits = 5'd8;
			wl_10: word_bits = 5'd10;
			wl_12: word_bits = 5'd12;
			wl_16: word_bits = 5'd16;
		endcase
	endfunction

	// Slot timing on the sampled bit clock
	logic [4:0] bit_cnt_q;
	logic [slots_w-1:0] slot_q;
	logic started_q;
	slot_mode_t mode_q;
	logic [15:0] shift_q;
	logic empty_q, under_q, answered_q, skip_req_q;
	wire [4:0] last_bit = word_bits(wl_sel) - 5'd1; // RQ15
	wire boundary = bclk_rise & (fs_rise | (started_q & (bit_cnt_q == last_bit)));
	// Frame sync restarts slot zero; otherwise advance and wrap
	wire [slots_w-1:0] next_slot = fs_rise ? '0 :
		(slot_q == slots_m1) ? '0 : slot_q + 1'b1; // RQ12 RQ16
	wire slot_on = mask_q[next_slot]; // RQ1 RQ3
	wire active = enable & boundary & slot_on;
	wire sw_write = wr_hold | wr_skip;
	// A skip write wins only if it was the last answer of the slot
	wire mute = skip_req_q & answered_q; // RQ8 RQ14

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bit_cnt_q <= 5'd0;
			slot_q <= '0;
			started_q <= 1'b0;
			mode_q <= slot_idle;
			shift_q <= 16'h0000;
		end else if (!enable) begin
			started_q <= 1'b0;
			mode_q <= slot_idle;
		end else if (boundary) begin
			bit_cnt_q <= 5'd0;
			slot_q <= next_slot;
			started_q <= 1'b1;
			if (!slot_on)
				mode_q <= slot_idle; // RQ2 RQ3 RQ11
			else if (mute)
				mode_q <= slot_mute; // RQ8
			else begin
				mode_q <= slot_drive; // RQ4 RQ9
				shift_q <= hold_q; // RQ4 RQ5
			end
		end else if (bclk_rise) begin
			bit_cnt_q <= bit_cnt_q + 5'd1;
			shift_q <= {shift_q[14:0], 1'b0}; // RQ10
		end
	end

	// Empty and underrun flags; hardware set wins over software clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			empty_q <= 1'b0;
			under_q <= 1'b0;
			answered_q <= 1'b0;
			skip_req_q <= 1'b0;
		end else begin
			if (active)
				empty_q <= 1'b1; // RQ6
			else if (sw_write)
				empty_q <= 1'b0; // RQ7
			if (active & started_q & ~answered_q)
				under_q <= 1'b1; // RQ9
			else if (wr_status & hwdata[st_under_bit])
				under_q <= 1'b0;
			if (active) begin
				answered_q <= 1'b0;
				skip_req_q <= 1'b0;
			end else if (sw_write) begin
				answered_q <= 1'b1;
				skip_req_q <= wr_skip;
			end
		end
	end

	// MSB first; the word sits in the low word_bits bits of the shift register
	wire [4:0] msb_idx = word_bits(wl_sel) - 5'd1;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			serial_tx_data_pin_o <= 1'b0;
			serial_tx_data_pin_oe <= 1'b0;
			tx_irq <= 1'b0;
		end else begin
			serial_tx_data_pin_o <= shift_q[msb_idx[3:0]];
			serial_tx_data_pin_oe <= (mode_q == slot_drive) & enable; // RQ11
			tx_irq <= empty_q & irq_en; // RQ6
		end
	end

	// Read data
	wire [31:0] status_word = {16'h0000, 3'h0, slot_q, 6'h00, under_q, empty_q};
	wire [31:0] rd_mux =
		(addr_q == ctrl_off) ? ctrl_q :
		(addr_q == status_off) ? status_word :
		(addr_q == mask_off) ? mask_q :
		(addr_q == hold_off) ? {16'h0000, hold_q} : 32'h0000_0000;
	assign hrdata = rd_pend_q ? rd_mux : 32'h0000_0000;
endmodule
`default_nettype wire

// ---- verilog/tdm_tx_pkg.sv ----
// Constants, register map and types for the slot-masked TDM transmitter
// Behaviour
// RQ1 - All mask bits set equals plain network mode
// RQ2 - Masked slot: no load, no interrupt
// RQ3 - Boundary checks next slot; zero tri-states pin
// RQ4 - Enabled slot loads holding into shift register
// RQ5 - Unwritten holding register is resent unchanged
// RQ6 - Enabled word start sets empty flag, interrupt
// RQ7 - Holding or skip write clears empty flag
// RQ8 - Skip write tri-states next enabled slot
// RQ9 - No write: underrun flag, drive, resend
// RQ10 - Shift one bit per bit clock rise
// RQ11 - Inactive slots keep pin high impedance
// RQ12 - Frame timing starts at frame sync rise
// RQ13 - Software must answer every enabled slot
// RQ14 - Skip write suppresses next slot transmission
// RQ15 - Word length selectable 8, 10, 12, 16
// RQ16 - Slot counter resets on sync, picks mask
package tdm_tx_pkg;
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] status_off = 8'h04;
	localparam logic [7:0] mask_off = 8'h08;
	localparam logic [7:0] hold_off = 8'h0c;
	localparam logic [7:0] skip_off = 8'h10;
	// Control fields
	localparam int ctrl_en_bit = 0;
	localparam int ctrl_ie_bit = 1;
	localparam int ctrl_wl_lo = 2;
	localparam int ctrl_slots_lo = 4;
	localparam int slots_w = 5;
	// Status fields
	localparam int st_empty_bit = 0;
	localparam int st_under_bit = 1;
	localparam int st_slot_lo = 8;
	localparam logic [31:0] ctrl_rst = 32'h0000_0000;
	localparam logic [31:0] mask_rst = 32'hffff_ffff;
	localparam logic [1:0] wl_8 = 2'h0;
	localparam logic [1:0] wl_10 = 2'h1;
	localparam logic [1:0] wl_12 = 2'h2;
	localparam logic [1:0] wl_16 = 2'h3;
	localparam logic [1:0] htrans_nonseq = 2'h2;
	typedef enum logic [1:0] {slot_idle, slot_drive, slot_mute} slot_mode_t;
endpackage

// ---- dv/tdm_far_end.sv ----
// Far end: continuous bit clock and bit-long frame sync
`timescale 1ns/100ps
`default_nettype none
module tdm_far_end #(
	parameter int frame_bits = 32
) (
	output logic bck,
	output logic fs
);
	int n = 0;
	initial begin
		bck = 0;
		fs = 0;
		forever begin
			#200 bck = ~bck;
			if (bck) begin
				fs = (n == 0);
				n = (n + 1) % frame_bits;
			end
		end
	end
endmodule
`default_nettype wire

// ---- dv/tdm_tx_slot_mask_properties.sv ----
// Port properties of the slot-masked transmitter
`timescale 1ns/100ps
`default_nettype none
module tdm_tx_slot_mask_properties
	import tdm_tx_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic tx_bit_clock,
	input wire logic serial_tx_data_pin_o,
	input wire logic serial_tx_data_pin_oe,
	input wire logic tx_irq
);
	wire wr = hsel && hready && htrans == htrans_nonseq && hwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	ok_resp_a: assert property (!hresp) else $error("bad response");
	zero_wait_a: assert property (hreadyout) else $error("wait state");
	reset_quiet_a: assert property (
		$fell(sys_rst) |-> !serial_tx_data_pin_oe && !tx_irq) else $error("active after reset");
	// Pins only move just after a bit-clock rise, never late in the low phase
	bit_timing_a: assert property (
		$fell(tx_bit_clock) |-> ##3 $stable(serial_tx_data_pin_o)[*3]) else $error("data moved");
	oe_timing_a: assert property (
		$fell(tx_bit_clock) |-> ##3 $stable(serial_tx_data_pin_oe)[*3]) else $error("enable moved");
	irq_rise_a: assert property (
		$fell(tx_bit_clock) |-> ##3 (!$rose(tx_irq))[*3]) else $error("request off boundary");
	hold_clear_a: assert property (
		wr && haddr[7:0] == hold_off |-> ##[2:4] !tx_irq) else $error("hold write kept request");
	skip_clear_a: assert property (
		wr && haddr[7:0] == skip_off |-> ##[2:4] !tx_irq) else $error("skip write kept request");
endmodule
bind tdm_tx_slot_mask tdm_tx_slot_mask_properties u_props (.clk, .sys_rst, .hsel, .haddr,
	.htrans, .hwrite, .hready, .hreadyout, .hresp, .tx_bit_clock, .serial_tx_data_pin_o,
	.serial_tx_data_pin_oe, .tx_irq);
`default_nettype wire

// ---- dv/tdm_tx_slot_mask_bench.sv ----
// Bench: software answering three of every four slot requests, serial capture against a queue
`timescale 1ns/100ps
`default_nettype none
module tdm_tx_slot_mask_bench;
	import tdm_tx_pkg::*;
	logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, bck, fs, pin, oe, irq, hrdy, hresp;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [7:0] sh, last;
	logic [7:0] exp_q[$];
	int errors = 0, samples_checked = 0, nb = 0, cyc = 0;
	tdm_tx_slot_mask u_dut (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hrdy), .hrdata, .hreadyout(hrdy), .hresp, .tx_bit_clock(bck),
		.tx_frame_sync(fs), .serial_tx_data_pin_o(pin), .serial_tx_data_pin_oe(oe), .tx_irq(irq));
	tdm_far_end u_far (.bck, .fs);
	initial forever #25 clk = ~clk;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1;
		htrans <= htrans_nonseq;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hrdy !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hrdy !== 1'b1);
		rd = hrdata;
	endtask
	// Word ends after eight driven bits, MSB first
	always @(posedge bck) begin
		if (oe === 1'b1) begin
			sh = {sh[6:0], pin};
			nb++;
			if (nb == 8) begin
				nb = 0;
				check(sh, exp_q.size() > 0 ? exp_q.pop_front() : ~sh);
			end
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		void'($urandom(32'h56d6));
		repeat (8) @(posedge clk);
		sys_rst <= 0;
		last = 8'($urandom);
		bus(1, hold_off, {24'h0, last});
		exp_q.push_back(last);
		bus(1, mask_off, 32'h9);
		bus(1, ctrl_off, 32'h33);
		for (int i = 0; i < 16; i++) begin
			while (irq !== 1'b1) @(posedge clk);
			if (i % 4 < 2) begin
				last = 8'($urandom);
				bus(1, hold_off, {24'h0, last});
				exp_q.push_back(last);
			end else if (i % 4 == 2) begin
				bus(1, skip_off, 32'h0);
			end else begin
				exp_q.push_back(last);
				while (oe !== 1'b1) @(posedge clk);
				bus(0, status_off, 32'h0);
				check(rd[7:0] & 8'h02, 8'h02);
				bus(1, status_off, 32'h2);
			end
			while (i % 4 < 3 && irq === 1'b1) @(posedge clk);
		end
		while (exp_q.size() > 0) @(posedge clk);
		close_out();
	end
endmodule
`default_nettype wire
